// ===== rtl/cfg_load_pkg.sv
// shared constants and types for the power-up configuration loader
package cfg_load_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int WDT_TIMEOUT_MS = 100;
	localparam int WDT_CYCLES = WDT_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	// the clock generator drops to this share of nominal rate in programming mode
	localparam int JTAG_CLK_PCT = 90;

	// ----------------------------------------------------------------
	// flash word layout
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int CHECK_W = 6;
	localparam int CODE_W = DATA_W + CHECK_W;
	localparam int ADDR_W = 8;
	localparam logic [CODE_W-1:0] BLANK_CODE = 38'h3f_ffff_ffff;

	// ----------------------------------------------------------------
	// flash regions; the last word of each holds its checksum
	// ----------------------------------------------------------------
	localparam int FW_BASE = 0;
	localparam int FW_WORDS = 16;
	localparam int CFG_BASE = 16;
	localparam int CFG_WORDS = 16;
	localparam int LOG_BASE = 32;
	localparam int LOG_WORDS = 8;

	// ----------------------------------------------------------------
	// address sensing and pins
	// ----------------------------------------------------------------
	localparam int SENSE_W = 7;
	localparam logic [SENSE_W-1:0] ADDR_JTAG = 7'h7e;
	localparam int ADDR_PINS = 2;
	localparam int JTAG_PINS = 6;
	localparam int JTAG_GPIO = 4;
	localparam int GPIO_W = 8;
	localparam int FAST_PULSE_WIDTH_OUT_W = 4;

	// ----------------------------------------------------------------
	// sequencer types
	// ----------------------------------------------------------------
	typedef enum {st_hold, st_sense, st_scan, st_erase, st_run} state_t;
	typedef enum {rg_fw, rg_cfg, rg_log} region_t;

endpackage : cfg_load_pkg

// ===== rtl/config_load_integrity.sv
// power-up integrity checks, programming-port enable and flash update control
`timescale 1ns/1ps
module config_load_integrity
	import cfg_load_pkg::*;
#(
	parameter int WDT_COUNT = WDT_CYCLES,
	parameter int GPIO_N = GPIO_W,
	parameter int FAST_PULSE_WIDTH_OUT_N = FAST_PULSE_WIDTH_OUT_W,
	parameter int FW_LEN = FW_WORDS,
	parameter int CFG_LEN = CFG_WORDS,
	parameter int LOG_LEN = LOG_WORDS
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [SENSE_W-1:0] addr_strap,
	input wire logic [ADDR_PINS-1:0] addr_pin_bad,
	output logic flash_rd_en,
	output logic [ADDR_W-1:0] flash_addr,
	input wire logic [CODE_W-1:0] flash_rdata,
	output logic flash_wr_en,
	output logic [CODE_W-1:0] flash_wdata,
	output logic flash_erase,
	output logic flash_erase_log,
	input wire logic host_wp_off,
	input wire logic host_erase,
	input wire logic host_wr,
	input wire logic [ADDR_W-1:0] host_wr_addr,
	input wire logic [DATA_W-1:0] host_wr_data,
	input wire logic param_valid,
	input wire logic [DATA_W-1:0] param_value,
	input wire logic [DATA_W-1:0] param_lo,
	input wire logic [DATA_W-1:0] param_hi,
	output logic param_ok,
	output logic param_bad,
	input wire logic wdt_kick,
	input wire logic status_clr,
	input wire logic [GPIO_N-1:0] core_gpio_out,
	input wire logic [GPIO_N-1:0] core_gpio_oe,
	input wire logic [FAST_PULSE_WIDTH_OUT_N-1:0] core_fast_pulse_width_out,
	output logic [GPIO_N-1:0] gpio_out,
	output logic [GPIO_N-1:0] gpio_oe,
	output logic [FAST_PULSE_WIDTH_OUT_N-1:0] fast_pulse_width_out,
	output logic jtag_en,
	output logic clk_slow_sel,
	output logic fw_exec_en,
	output logic use_defaults,
	output logic cfg_sum_flag,
	output logic bus_alert_n,
	output logic log_erased,
	output logic fault_log_en,
	output logic ecc_fixed,
	output logic init_done
);

	localparam logic [GPIO_N-1:0] SHARED_MASK = GPIO_N'((1 << JTAG_GPIO) - 1);

	state_t state;
	region_t region;
	logic [ADDR_W-1:0] idx;
	logic rd_q;
	logic [SENSE_W-1:0] sensed_addr;
	logic cfg_blank;
	logic cfg_dirty;
	logic [31:0] wdt_cnt;
	logic wdt_expire;
	logic [ADDR_W-1:0] reg_base;
	logic [ADDR_W-1:0] reg_last;
	logic last_word;
	logic sum_match;
	logic [DATA_W-1:0] rd_data;
	logic rd_fixed;
	logic [CODE_W-1:0] wr_code;
	logic [DATA_W-1:0] sum;
	logic cfg_bad;
	logic log_bad;
	logic fw_bad;

	// ----------------------------------------------------------------
	// flash word coding and checksum
	// ----------------------------------------------------------------
	ecc_codec u_ecc (
		.enc_data(host_wr_data),
		.enc_code(wr_code),
		.dec_code(flash_rdata),
		.dec_data(rd_data),
		.dec_fixed(rd_fixed)
	);

	word_sum u_sum (
		.clk(clk),
		.nrst(nrst),
		.clr(state != st_scan || (rd_q && last_word)),
		.add(rd_q && !last_word),
		.data(rd_data),
		.sum(sum)
	);

	always_comb
	begin
		case (region)
			rg_fw:
			begin
				reg_base = ADDR_W'(FW_BASE);
				reg_last = ADDR_W'(FW_LEN - 1);
			end
			rg_cfg:
			begin
				reg_base = ADDR_W'(CFG_BASE);
				reg_last = ADDR_W'(CFG_LEN - 1);
			end
			default:
			begin
				reg_base = ADDR_W'(LOG_BASE);
				reg_last = ADDR_W'(LOG_LEN - 1);
			end
		endcase
	end

	assign last_word = (idx == reg_last);
	assign sum_match = (sum == rd_data);
	assign fw_bad = state == st_scan && rd_q && last_word && region == rg_fw && !sum_match;
	assign cfg_bad = state == st_scan && rd_q && last_word && region == rg_cfg
		&& !sum_match && !(cfg_blank && flash_rdata == BLANK_CODE);
	assign log_bad = state == st_scan && rd_q && last_word && region == rg_log && !sum_match;
	assign wdt_expire = state == st_run && fw_exec_en && !wdt_kick
		&& wdt_cnt == 32'(WDT_COUNT - 1);

	// ----------------------------------------------------------------
	// power-up sequencer: hold, sense address, scan fw, cfg, log
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= st_hold;
			region <= rg_fw;
			idx <= '0;
		end
		else
		begin
			case (state)
				st_hold:
					state <= st_sense;
				st_sense:
				begin
					state <= st_scan;
					region <= rg_fw;
					idx <= '0;
				end
				st_scan:
					if (rd_q)
					begin
						if (!last_word)
							idx <= ADDR_W'(idx + 1'b1);
						else
						begin
							idx <= '0;
							case (region)
								rg_fw:
									region <= rg_cfg;
								rg_cfg:
									region <= rg_log;
								default:
									state <= log_bad ? st_erase : st_run;
							endcase
						end
					end
				st_erase:
					state <= st_run;
				st_run:
					if (wdt_expire)
						state <= st_hold;
				default:
					state <= st_hold;
			endcase
		end
	end

	// one word in flight at a time keeps the sum aligned with the index
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flash_rd_en <= 1'b0;
			rd_q <= 1'b0;
			ecc_fixed <= 1'b0;
		end
		else
		begin
			flash_rd_en <= state == st_scan && !flash_rd_en && !rd_q;
			rd_q <= flash_rd_en;
			ecc_fixed <= rd_q && rd_fixed;
		end
	end

	// ----------------------------------------------------------------
	// flash address and live update path
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flash_addr <= '0;
			flash_wr_en <= 1'b0;
			flash_wdata <= '0;
			flash_erase <= 1'b0;
			flash_erase_log <= 1'b0;
		end
		else
		begin
			flash_wr_en <= state == st_run && host_wr && host_wp_off;
			flash_erase <= state == st_run && host_erase && host_wp_off;
			flash_erase_log <= state == st_erase;
			if (state == st_scan)
				flash_addr <= ADDR_W'(reg_base + idx);
			else if (host_wr)
				flash_addr <= host_wr_addr;
			if (host_wr)
				flash_wdata <= wr_code;
		end
	end

	// running config stays in use; only logging stops until the next reset
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_dirty <= 1'b0;
			fault_log_en <= 1'b0;
		end
		else
		begin
			if (state == st_hold)
				cfg_dirty <= 1'b0;
			else if (state == st_run && host_wp_off && (host_wr || host_erase))
				cfg_dirty <= 1'b1;
			fault_log_en <= state == st_run && !cfg_dirty
				&& !(host_wp_off && (host_wr || host_erase));
		end
	end

	// ----------------------------------------------------------------
	// integrity results and programming-port decision
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sensed_addr <= '0;
			cfg_blank <= 1'b1;
			jtag_en <= 1'b0;
			clk_slow_sel <= 1'b0;
			fw_exec_en <= 1'b0;
			use_defaults <= 1'b0;
			log_erased <= 1'b0;
		end
		else if (state == st_hold)
		begin
			cfg_blank <= 1'b1;
			jtag_en <= 1'b0;
			clk_slow_sel <= 1'b0;
			fw_exec_en <= 1'b0;
			use_defaults <= 1'b0;
			log_erased <= 1'b0;
		end
		else
		begin
			if (state == st_sense)
			begin
				sensed_addr <= (|addr_pin_bad) ? ADDR_JTAG : addr_strap;
				if ((|addr_pin_bad) || addr_strap == ADDR_JTAG)
				begin
					jtag_en <= 1'b1;
					clk_slow_sel <= 1'b1;
				end
			end
			if (state == st_scan && rd_q && region == rg_cfg && flash_rdata != BLANK_CODE)
				cfg_blank <= 1'b0;
			if (state == st_scan && rd_q && last_word && region == rg_cfg
				&& cfg_blank && flash_rdata == BLANK_CODE)
			begin
				jtag_en <= 1'b1;
				clk_slow_sel <= 1'b1;
				use_defaults <= 1'b1;
			end
			if (state == st_scan && rd_q && last_word && region == rg_fw)
				fw_exec_en <= sum_match;
			if (cfg_bad)
				use_defaults <= 1'b1;
			if (state == st_erase)
				log_erased <= 1'b1;
		end
	end

	// a mismatch landing with a clear still sets the flag
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_sum_flag <= 1'b0;
			bus_alert_n <= 1'b1;
		end
		else
		begin
			cfg_sum_flag <= cfg_bad || (cfg_sum_flag && !status_clr);
			bus_alert_n <= !(cfg_bad || (cfg_sum_flag && !status_clr));
		end
	end

	// ----------------------------------------------------------------
	// watchdog and parameter range check
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			wdt_cnt <= '0;
		else if (state != st_run || wdt_kick || wdt_expire)
			wdt_cnt <= '0;
		else if (fw_exec_en)
			wdt_cnt <= 32'(wdt_cnt + 1'b1);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			param_ok <= 1'b0;
			param_bad <= 1'b0;
		end
		else
		begin
			param_ok <= param_valid && param_value >= param_lo && param_value <= param_hi;
			param_bad <= param_valid && (param_value < param_lo || param_value > param_hi);
		end
	end

	// ----------------------------------------------------------------
	// pin release; the tap itself carries programming only, no scan chain
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			init_done <= 1'b0;
			gpio_out <= '0;
			gpio_oe <= '0;
			fast_pulse_width_out <= '0;
		end
		else
		begin
			init_done <= state == st_run;
			gpio_out <= (state == st_run) ? core_gpio_out : '0;
			if (state != st_run)
				gpio_oe <= '0;
			else if (jtag_en)
				gpio_oe <= core_gpio_oe & ~SHARED_MASK;
			else
				gpio_oe <= core_gpio_oe;
			fast_pulse_width_out <= (state == st_run) ? core_fast_pulse_width_out : '0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence seq_cfg_mismatch;
		cfg_bad;
	endsequence

	sequence seq_log_mismatch;
		log_bad ##1 state == st_erase;
	endsequence

	hold_pins_a: assert property (@(posedge clk) disable iff (!nrst)
		state == st_hold |=> gpio_oe == '0 && fast_pulse_width_out == '0)
		else $error("pins driven while held in reset");
	addr_jtag_a: assert property (@(posedge clk) disable iff (!nrst)
		state == st_sense && addr_strap == ADDR_JTAG |=> jtag_en && clk_slow_sel)
		else $error("address 126 did not enable programming port");
	addr_fault_a: assert property (@(posedge clk) disable iff (!nrst)
		state == st_sense && (|addr_pin_bad) |=> jtag_en && sensed_addr == ADDR_JTAG)
		else $error("bad address pin did not sense as 126");
	port_off_a: assert property (@(posedge clk) disable iff (!nrst)
		init_done && !cfg_blank && sensed_addr != ADDR_JTAG |-> !jtag_en)
		else $error("programming port enabled without cause");
	shared_pins_a: assert property (@(posedge clk) disable iff (!nrst)
		jtag_en |-> (gpio_oe & SHARED_MASK) == '0)
		else $error("shared pin driven while port enabled");
	fw_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		fw_bad |=> !fw_exec_en [*2])
		else $error("firmware enabled after checksum failure");
	cfg_alert_a: assert property (@(posedge clk) disable iff (!nrst)
		seq_cfg_mismatch |=> !bus_alert_n && cfg_sum_flag)
		else $error("config mismatch did not raise alert");
	cfg_default_a: assert property (@(posedge clk) disable iff (!nrst)
		seq_cfg_mismatch |=> use_defaults)
		else $error("defaults not loaded after config mismatch");
	log_erase_a: assert property (@(posedge clk) disable iff (!nrst)
		seq_log_mismatch |=> flash_erase_log ##1 state == st_run)
		else $error("corrupt log not erased");
	wdt_reset_a: assert property (@(posedge clk) disable iff (!nrst)
		wdt_expire |=> state == st_hold ##1 state == st_sense)
		else $error("watchdog timeout did not reset");
	release_a: assert property (@(posedge clk) disable iff (!nrst)
		!init_done |-> gpio_oe == '0 && fast_pulse_width_out == '0)
		else $error("pins released before checks finished");
	log_off_a: assert property (@(posedge clk) disable iff (!nrst)
		cfg_dirty |-> !fault_log_en)
		else $error("logging active after live rewrite");
	range_a: assert property (@(posedge clk) disable iff (!nrst)
		param_valid && param_value > param_hi |=> param_bad && !param_ok)
		else $error("out of range parameter accepted");

endmodule : config_load_integrity

// ===== rtl/ecc_codec.sv
// single-error-correcting hamming coder for flash words
`timescale 1ns/1ps
module ecc_codec
	import cfg_load_pkg::*;
#(
	parameter int D_W = DATA_W,
	parameter int C_W = CODE_W
)
(
	input wire logic [D_W-1:0] enc_data,
	output logic [C_W-1:0] enc_code,
	input wire logic [C_W-1:0] dec_code,
	output logic [D_W-1:0] dec_data,
	output logic dec_fixed
);

	function automatic logic is_pow2(input int v);
		return (v & (v - 1)) == 0;
	endfunction : is_pow2

	// ----------------------------------------------------------------
	// encode: data in non power-of-two positions, check bits at 1,2,4..
	// ----------------------------------------------------------------
	always_comb
	begin
		int d;
		logic [C_W-1:0] cw;
		d = 0;
		cw = '0;
		for (int pos = 1; pos <= C_W; pos++)
			if (!is_pow2(pos))
			begin
				cw[pos-1] = enc_data[d];
				d++;
			end
		for (int p = 0; p < CHECK_W; p++)
			for (int pos = 1; pos <= C_W; pos++)
				if (pos[p] && !is_pow2(pos))
					cw[(1 << p) - 1] = cw[(1 << p) - 1] ^ cw[pos-1];
		enc_code = cw;
	end

	// ----------------------------------------------------------------
	// decode: syndrome is the position of a single flipped bit
	// ----------------------------------------------------------------
	always_comb
	begin
		int d;
		logic [CHECK_W-1:0] syn;
		logic [C_W-1:0] cw;
		d = 0;
		syn = '0;
		cw = dec_code;
		dec_data = '0;
		for (int pos = 1; pos <= C_W; pos++)
			if (dec_code[pos-1])
				syn = syn ^ CHECK_W'(pos);
		if (syn != '0 && int'(syn) <= C_W)
			cw[syn-1] = ~cw[syn-1];
		for (int pos = 1; pos <= C_W; pos++)
			if (!is_pow2(pos))
			begin
				dec_data[d] = cw[pos-1];
				d++;
			end
		dec_fixed = (syn != '0);
	end

endmodule : ecc_codec

// ===== rtl/word_sum.sv
// running 32-bit sum over a stream of flash words
`timescale 1ns/1ps
module word_sum
	import cfg_load_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic add,
	input wire logic [W-1:0] data,
	output logic [W-1:0] sum
);

	// clear wins so a region boundary never leaks a word into the next sum
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			sum <= '0;
		else if (clr)
			sum <= '0;
		else if (add)
			sum <= W'(sum + data);
	end

endmodule : word_sum

// ===== verification/config_load_integrity_tb_top.sv
// self-checking bench for the power-up configuration loader
`timescale 1ns/1ps
module config_load_integrity_tb_top;
	import cfg_load_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic clk = 1'b0, nrst = 1'b0, kick_on = 1'b1, wdt_kick = 1'b0, status_clr = 1'b0;
	logic host_wp_off = 1'b0, host_erase = 1'b0, host_wr = 1'b0, param_valid = 1'b0;
	logic [SENSE_W-1:0] addr_strap = 7'h20;
	logic [ADDR_PINS-1:0] addr_pin_bad = 2'h0;
	logic [ADDR_W-1:0] host_wr_addr = 8'h0, flash_addr;
	logic [DATA_W-1:0] host_wr_data = 32'h0, param_value = 32'h0, param_lo = 32'h0;
	logic [DATA_W-1:0] param_hi = 32'h0;
	logic [GPIO_W-1:0] core_gpio_out = 8'ha5, core_gpio_oe = 8'h3c, gpio_out, gpio_oe;
	logic [FAST_PULSE_WIDTH_OUT_W-1:0] core_fast_pulse_width_out = 4'h9, fast_pulse_width_out;
	logic [CODE_W-1:0] flash_rdata, flash_wdata;
	logic flash_rd_en, flash_wr_en, flash_erase, flash_erase_log, param_ok, param_bad;
	logic jtag_en, clk_slow_sel, fw_exec_en, use_defaults, cfg_sum_flag, bus_alert_n;
	logic log_erased, fault_log_en, ecc_fixed, init_done;
	int mismatches = 0, samples_checked = 0, fix_cnt = 0, elog_cnt = 0;

	always #50 clk = ~clk;
	// kick pulses every other cycle so the watchdog stays quiet unless a test stops it
	always @(negedge clk) wdt_kick <= kick_on & ~wdt_kick;
	always @(posedge clk)
	begin
		if (ecc_fixed === 1'b1)
			fix_cnt++;
		if (flash_erase_log === 1'b1)
			elog_cnt++;
	end

	config_load_integrity #(.WDT_COUNT(20)) config_load_integrity_i (.clk(clk), .nrst(nrst),
		.addr_strap(addr_strap), .addr_pin_bad(addr_pin_bad), .flash_rd_en(flash_rd_en),
		.flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_wr_en(flash_wr_en),
		.flash_wdata(flash_wdata), .flash_erase(flash_erase), .flash_erase_log(flash_erase_log),
		.host_wp_off(host_wp_off), .host_erase(host_erase), .host_wr(host_wr),
		.host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data), .param_valid(param_valid),
		.param_value(param_value), .param_lo(param_lo), .param_hi(param_hi),
		.param_ok(param_ok), .param_bad(param_bad), .wdt_kick(wdt_kick),
		.status_clr(status_clr), .core_gpio_out(core_gpio_out), .core_gpio_oe(core_gpio_oe),
		.core_fast_pulse_width_out(core_fast_pulse_width_out), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.fast_pulse_width_out(fast_pulse_width_out), .jtag_en(jtag_en),
		.clk_slow_sel(clk_slow_sel), .fw_exec_en(fw_exec_en), .use_defaults(use_defaults),
		.cfg_sum_flag(cfg_sum_flag), .bus_alert_n(bus_alert_n), .log_erased(log_erased),
		.fault_log_en(fault_log_en), .ecc_fixed(ecc_fixed), .init_done(init_done));
	flash_model flash_model_i (.clk(clk), .rd_en(flash_rd_en), .addr(flash_addr),
		.rdata(flash_rdata), .wr_en(flash_wr_en), .wdata(flash_wdata), .erase(flash_erase),
		.erase_log(flash_erase_log));

	// ----------------------------------------------------------------
	// checks and helpers
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk1(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk1
	task automatic chkv(input string name, input logic [CODE_W-1:0] exp,
		input logic [CODE_W-1:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chkv
	// own hamming coder: data fills the non power-of-two positions upward
	function automatic logic [CODE_W-1:0] enc(input logic [DATA_W-1:0] d);
		logic [CODE_W-1:0] c;
		logic [5:0] syn;
		int j;
		c = '0;
		syn = '0;
		j = 0;
		for (int p = 1; p <= CODE_W; p++)
		begin
			if ((p & (p - 1)) != 0)
			begin
				c[p-1] = d[j];
				if (d[j])
					syn = syn ^ 6'(p);
				j++;
			end
		end
		for (int k = 0; k < CHECK_W; k++)
			c[(1 << k) - 1] = syn[k];
		return c;
	endfunction : enc
	task automatic fill(input int base, input int len, input int bad, input logic blank);
		logic [DATA_W-1:0] s;
		logic [DATA_W-1:0] d;
		s = '0;
		for (int k = 0; k < len; k++)
		begin
			d = {24'h5a3ce1, 8'(k + base)};
			if (k == len - 1)
				d = s + 32'(bad);
			else
				s = s + d;
			flash_model_i.mem[base + k] = blank ? BLANK_CODE : enc(d);
		end
		flash_model_i.mem[40] = BLANK_CODE;
	endtask : fill
	task automatic load(input int fw, input int cfg, input int lg, input logic blank);
		fill(FW_BASE, FW_WORDS, fw, 1'b0);
		fill(CFG_BASE, CFG_WORDS, cfg, blank);
		fill(LOG_BASE, LOG_WORDS, lg, 1'b0);
	endtask : load
	task automatic boot();
		int n;
		logic [GPIO_W-1:0] pre;
		pre = '1;
		@(negedge clk);
		nrst = 1'b0;
		repeat (20) @(negedge clk);
		chkv("gpio_oe in reset", '0, 38'(gpio_oe));
		chkv("fast_pulse_width_out in reset", '0, 38'(fast_pulse_width_out));
		nrst = 1'b1;
		n = 0;
		while (init_done !== 1'b1 && n < 400)
		begin
			pre = gpio_oe;
			@(negedge clk);
			n++;
		end
		chk1("init_done", 1'b1, init_done);
		if (n == 400)
			end_sim();
		// pins come free on the same edge as init_done; the cycle before must be quiet
		chkv("gpio_oe before release", '0, 38'(pre));
	endtask : boot
	task automatic hpulse(input logic er, input logic wr, input logic [DATA_W-1:0] d);
		@(negedge clk);
		host_erase = er;
		host_wr = wr;
		host_wr_addr = 8'h28;
		host_wr_data = d;
		@(negedge clk);
		host_erase = 1'b0;
		host_wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask : hpulse
	task automatic param(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi,
		input logic exp);
		logic ok;
		logic bad;
		ok = 1'b0;
		bad = 1'b0;
		@(negedge clk);
		{param_value, param_lo, param_hi, param_valid} = {v, lo, hi, 1'b1};
		for (int i = 0; i < 3; i++)
		begin
			@(negedge clk);
			param_valid = 1'b0;
			ok = ok | (param_ok === 1'b1);
			bad = bad | (param_bad === 1'b1);
		end
		chk1("param_ok", exp, ok);
		chk1("param_bad", ~exp, bad);
	endtask : param

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_good();
		load(0, 0, 0, 1'b0);
		boot();
		chk1("jtag_en", 1'b0, jtag_en);
		chk1("fw_exec_en", 1'b1, fw_exec_en);
		chk1("use_defaults", 1'b0, use_defaults);
		chk1("bus_alert_n", 1'b1, bus_alert_n);
		chk1("log_erased", 1'b0, log_erased);
		@(negedge clk);
		chkv("gpio_oe", 38'(core_gpio_oe), 38'(gpio_oe));
		chkv("gpio_out", 38'(core_gpio_out), 38'(gpio_out));
		chkv("fast_pulse_width_out", 38'(core_fast_pulse_width_out), 38'(fast_pulse_width_out));
		param(32'h10, 32'h10, 32'h20, 1'b1);
		param(32'h20, 32'h10, 32'h20, 1'b1);
		param(32'hf, 32'h10, 32'h20, 1'b0);
		param(32'h21, 32'h10, 32'h20, 1'b0);
		$display("test good_image done");
	endtask : t_good
	task automatic t_jtag();
		for (int i = 0; i < 3; i++)
		begin
			addr_strap = (i == 0) ? ADDR_JTAG : 7'h20;
			addr_pin_bad = 2'(i);
			boot();
			chk1("jtag_en", 1'b1, jtag_en);
			chk1("clk_slow_sel", 1'b1, clk_slow_sel);
			chkv("shared gpio_oe", 38'h30, 38'(gpio_oe));
		end
		addr_strap = 7'h20;
		addr_pin_bad = 2'h0;
		load(0, 0, 0, 1'b1);
		boot();
		chk1("blank jtag_en", 1'b1, jtag_en);
		chk1("blank use_defaults", 1'b1, use_defaults);
		chk1("blank bus_alert_n", 1'b1, bus_alert_n);
		$display("test jtag_enable done");
	endtask : t_jtag
	task automatic t_sums();
		load(0, 1, 0, 1'b0);
		boot();
		chk1("use_defaults", 1'b1, use_defaults);
		chk1("cfg_sum_flag", 1'b1, cfg_sum_flag);
		chk1("bus_alert_n", 1'b0, bus_alert_n);
		@(negedge clk);
		status_clr = 1'b1;
		@(negedge clk);
		status_clr = 1'b0;
		repeat (2) @(negedge clk);
		chk1("cleared alert", 1'b1, bus_alert_n);
		load(1, 0, 0, 1'b0);
		boot();
		kick_on = 1'b0;
		param(32'h5, 32'h1, 32'h9, 1'b1);
		repeat (40) @(negedge clk);
		chk1("fw_exec_en", 1'b0, fw_exec_en);
		chk1("no wdt reset", 1'b1, init_done);
		kick_on = 1'b1;
		load(0, 0, 1, 1'b0);
		elog_cnt = 0;
		boot();
		chkv("log erase pulses", 38'h1, 38'(elog_cnt));
		chk1("log_erased", 1'b1, log_erased);
		chkv("log word", BLANK_CODE, flash_model_i.mem[LOG_BASE]);
		$display("test checksums done");
	endtask : t_sums
	task automatic t_ecc_wdt();
		int n;
		load(0, 0, 0, 1'b0);
		flash_model_i.mem[3][5] = ~flash_model_i.mem[3][5];
		flash_model_i.mem[20][0] = ~flash_model_i.mem[20][0];
		flash_model_i.mem[33][37] = ~flash_model_i.mem[33][37];
		fix_cnt = 0;
		boot();
		chkv("ecc fixes", 38'h3, 38'(fix_cnt));
		chk1("corrected fw", 1'b1, fw_exec_en);
		chk1("corrected cfg", 1'b0, use_defaults);
		kick_on = 1'b0;
		n = 0;
		while (init_done === 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		kick_on = 1'b1;
		chk1("wdt timeout window", 1'b1, n >= 18 && n <= 24);
		boot();
		chk1("fw after wdt", 1'b1, fw_exec_en);
		$display("test ecc_watchdog done");
	endtask : t_ecc_wdt
	task automatic t_update();
		load(0, 0, 0, 1'b0);
		boot();
		hpulse(1'b0, 1'b1, 32'hdead_beef);
		chkv("locked write", BLANK_CODE, flash_model_i.mem[40]);
		chk1("log on", 1'b1, fault_log_en);
		host_wp_off = 1'b1;
		hpulse(1'b1, 1'b0, 32'h0);
		chkv("erased cfg", BLANK_CODE, flash_model_i.mem[CFG_BASE]);
		hpulse(1'b0, 1'b1, 32'hdead_beef);
		chkv("encoded word", enc(32'hdead_beef), flash_model_i.mem[40]);
		chk1("log off", 1'b0, fault_log_en);
		chk1("old cfg kept", 1'b0, use_defaults);
		host_wp_off = 1'b0;
		boot();
		chk1("new cfg blank", 1'b1, use_defaults);
		$display("test live_update done");
	endtask : t_update

	initial
	begin
		t_good();
		t_jtag();
		t_sums();
		t_ecc_wdt();
		t_update();
		end_sim();
	end
endmodule : config_load_integrity_tb_top

// ===== verification/flash_model.sv
// flash array model answering the loader's read, write and erase strobes
`timescale 1ns/1ps
module flash_model
	import cfg_load_pkg::*;
(
	input wire logic clk,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] addr,
	output logic [CODE_W-1:0] rdata,
	input wire logic wr_en,
	input wire logic [CODE_W-1:0] wdata,
	input wire logic erase,
	input wire logic erase_log
);
	logic [CODE_W-1:0] mem [0:255];
	initial
	begin
		rdata = '0;
	end
	// an idle read port toggles so a stale word can never pass for a fresh one
	always @(posedge clk)
	begin
		rdata <= rd_en ? mem[addr] : ~rdata;
		if (wr_en)
			mem[addr] <= wdata;
		for (int k = 0; k < 64; k++)
		begin
			if (erase && k >= CFG_BASE && k < CFG_BASE + CFG_WORDS)
				mem[k] <= BLANK_CODE;
			if (erase_log && k >= LOG_BASE && k < LOG_BASE + LOG_WORDS)
				mem[k] <= BLANK_CODE;
		end
	end
endmodule : flash_model
